// ### smb_pkg.sv
// Purpose: Shared constants and types for the serial master byte engine
// Assumes: Byte-wide transfers, two slave selects
// Notes: Link-side counts are in link clock cycles
package smb_pkg;
    localparam int BYTE_W = 8;
    localparam int DIV_W = 8;
    localparam int EDGE_W = 5;
    localparam int SS_W = 2;
    localparam logic [EDGE_W-1:0] EDGE_FIRST = 5'h00;
    localparam logic [EDGE_W-1:0] EDGE_LAST = 5'h0f;
    localparam logic [EDGE_W-1:0] EDGE_STEP = 5'h01;
    localparam logic [DIV_W-1:0] CNT_STEP = 8'h01;
    localparam logic [DIV_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [SS_W-1:0] SS_N_IDLE = 2'h3;
    localparam logic [SS_W-1:0] SS_N_SEL0 = 2'h2;
    localparam logic [SS_W-1:0] SS_N_SEL1 = 2'h1;
    localparam logic [BYTE_W-1:0] RX_ONLY_FILL = 8'hff;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam int MSB = BYTE_W - 1;

    typedef enum logic [1:0] {
        DUPLEX_FULL = 2'h0,
        DUPLEX_TX_ONLY = 2'h1,
        DUPLEX_RX_ONLY = 2'h2
    } smb_duplex_e;

    typedef enum logic [2:0] {
        M_IDLE = 3'h1,
        M_SEND = 3'h2,
        M_HOLD = 3'h4
    } smb_main_e;

    typedef enum logic [4:0] {
        L_IDLE = 5'h01,
        L_LEAD = 5'h02,
        L_SHIFT = 5'h04,
        L_HOLD = 5'h08,
        L_TAIL = 5'h10
    } smb_link_e;
endpackage

// ### smb_link_if.sv
// Purpose: Bundle crossing between the system-clock side and the link-clock shifter
// Assumes: Request fields are held stable from a request toggle until its acknowledge
// Notes: Toggle handshake; rx_byte is stable from the acknowledge until the next request
`timescale 1ns/1ps
interface smb_link_if;
    logic req_tgl;
    logic [smb_pkg::BYTE_W-1:0] tx_byte;
    logic first;
    logic last;
    logic cpol;
    logic cpha;
    logic ss_sel;
    logic [smb_pkg::DIV_W-1:0] clk_div;
    logic [smb_pkg::DIV_W-1:0] ss_delay;
    logic ack_tgl;
    logic [smb_pkg::BYTE_W-1:0] rx_byte;

    modport main (
        output req_tgl, tx_byte, first, last, cpol, cpha, ss_sel, clk_div, ss_delay,
        input ack_tgl, rx_byte
    );
    modport link (
        input req_tgl, tx_byte, first, last, cpol, cpha, ss_sel, clk_div, ss_delay,
        output ack_tgl, rx_byte
    );
endinterface

// ### smb_sync.sv
// Purpose: Two flip-flop level synchroniser
// Assumes: Each bit is an independent level or a toggle
// Notes: Only the second stage may be read
`timescale 1ns/1ps
module smb_sync #(
    parameter int W = 1
) (
    // Clock
    input wire logic i_clk,
    // Asynchronous level in
    input wire logic [W-1:0] i_d,
    // Synchronised level out
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge i_clk) begin
        meta_ff <= i_d;
        sync_ff <= meta_ff;
    end

    assign o_q = sync_ff;
endmodule

// ### smb_shifter.sv
// Purpose: Link-clock side: slave selects, serial clock and the byte shift register
// Assumes: Link clock runs free; reset is already synchronous to it
// Notes: Half serial-clock period is clk_div+1 link cycles
`timescale 1ns/1ps
module smb_shifter (
    // Link clock and reset
    input wire logic i_lclk,
    input wire logic i_lrst,
    // Crossing bundle
    smb_link_if.link lnk,
    // Serial pins
    input wire logic i_miso,
    output logic o_sclk,
    output logic o_mosi,
    output logic [smb_pkg::SS_W-1:0] o_ss_n
);
    smb_pkg::smb_link_e state_ff;
    logic [smb_pkg::DIV_W-1:0] cnt_ff;
    logic [smb_pkg::EDGE_W-1:0] edge_ff;
    logic [smb_pkg::BYTE_W-1:0] sh_ff;
    logic [smb_pkg::BYTE_W-1:0] rx_ff;
    logic [smb_pkg::SS_W-1:0] ss_n_ff;
    logic sclk_ff, mosi_ff, ack_ff, seen_ff;
    logic req_s, miso_s;
    logic req_evt, tick, load, clk_edge, leading, shift_edge, byte_end;

    smb_sync #(.W(1)) u_req_sync (.i_clk(i_lclk), .i_d(lnk.req_tgl), .o_q(req_s));
    smb_sync #(.W(1)) u_miso_sync (.i_clk(i_lclk), .i_d(i_miso), .o_q(miso_s));

    assign req_evt = req_s ^ seen_ff;
    assign tick = (cnt_ff == smb_pkg::CNT_ZERO);
    assign load = req_evt && (state_ff == smb_pkg::L_IDLE || state_ff == smb_pkg::L_HOLD);
    assign clk_edge = (state_ff == smb_pkg::L_SHIFT) && tick;
    assign leading = ~edge_ff[0];
    // Phase 0 shifts on trailing edges, phase 1 on leading edges
    assign shift_edge = (leading == lnk.cpha);
    assign byte_end = clk_edge && (edge_ff == smb_pkg::EDGE_LAST);

    // Sequencer: select, lead delay, 16 clock edges, hold or tail
    always_ff @(posedge i_lclk) begin
        if (i_lrst) begin
            state_ff <= smb_pkg::L_IDLE;
            cnt_ff <= smb_pkg::CNT_ZERO;
            edge_ff <= smb_pkg::EDGE_FIRST;
            seen_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                smb_pkg::L_IDLE: begin
                    if (req_evt) begin
                        seen_ff <= req_s;
                        cnt_ff <= lnk.ss_delay;
                        state_ff <= smb_pkg::L_LEAD;
                    end
                end
                smb_pkg::L_LEAD: begin
                    if (tick) begin
                        cnt_ff <= lnk.clk_div;
                        edge_ff <= smb_pkg::EDGE_FIRST;
                        state_ff <= smb_pkg::L_SHIFT;
                    end else begin
                        cnt_ff <= cnt_ff - smb_pkg::CNT_STEP;
                    end
                end
                smb_pkg::L_SHIFT: begin
                    if (tick) begin
                        cnt_ff <= lnk.clk_div;
                        edge_ff <= edge_ff + smb_pkg::EDGE_STEP;
                        if (edge_ff == smb_pkg::EDGE_LAST) begin
                            state_ff <= lnk.last ? smb_pkg::L_TAIL : smb_pkg::L_HOLD;
                        end
                    end else begin
                        cnt_ff <= cnt_ff - smb_pkg::CNT_STEP;
                    end
                end
                smb_pkg::L_HOLD: begin
                    if (req_evt) begin
                        seen_ff <= req_s;
                        cnt_ff <= lnk.clk_div;
                        edge_ff <= smb_pkg::EDGE_FIRST;
                        state_ff <= smb_pkg::L_SHIFT;
                    end
                end
                smb_pkg::L_TAIL: begin
                    if (tick) begin
                        state_ff <= smb_pkg::L_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - smb_pkg::CNT_STEP;
                    end
                end
            endcase
        end
    end

    // Slave selects: asserted before any clock, released only at the tail
    always_ff @(posedge i_lclk) begin
        if (i_lrst) begin
            ss_n_ff <= smb_pkg::SS_N_IDLE;
        end else if (state_ff == smb_pkg::L_IDLE && req_evt && lnk.first) begin
            ss_n_ff <= lnk.ss_sel ? smb_pkg::SS_N_SEL1 : smb_pkg::SS_N_SEL0;
        end else if (state_ff == smb_pkg::L_TAIL && tick) begin
            ss_n_ff <= smb_pkg::SS_N_IDLE;
        end
    end

    // Serial clock rests at idle polarity outside the shift
    always_ff @(posedge i_lclk) begin
        if (i_lrst) begin
            sclk_ff <= 1'b0;
        end else if (clk_edge) begin
            sclk_ff <= ~sclk_ff;
        end else if (state_ff != smb_pkg::L_SHIFT) begin
            sclk_ff <= lnk.cpol;
        end
    end

    // Transmit shifter, MSB first
    always_ff @(posedge i_lclk) begin
        if (i_lrst) begin
            sh_ff <= smb_pkg::BYTE_ZERO;
            mosi_ff <= 1'b0;
        end else if (load) begin
            if (lnk.cpha) begin
                sh_ff <= lnk.tx_byte;
            end else begin
                mosi_ff <= lnk.tx_byte[smb_pkg::MSB];
                sh_ff <= {lnk.tx_byte[smb_pkg::MSB-1:0], 1'b0};
            end
        end else if (clk_edge && shift_edge && !byte_end) begin
            mosi_ff <= sh_ff[smb_pkg::MSB];
            sh_ff <= {sh_ff[smb_pkg::MSB-1:0], 1'b0};
        end
    end

    // Receive shifter, captured on the opposite edges
    always_ff @(posedge i_lclk) begin
        if (i_lrst) begin
            rx_ff <= smb_pkg::BYTE_ZERO;
        end else if (clk_edge && !shift_edge) begin
            rx_ff <= {rx_ff[smb_pkg::MSB-1:0], miso_s};
        end
    end

    // Acknowledge toggles once per byte
    always_ff @(posedge i_lclk) begin
        if (i_lrst) begin
            ack_ff <= 1'b0;
        end else if ((byte_end && !lnk.last) || (state_ff == smb_pkg::L_TAIL && tick)) begin
            ack_ff <= ~ack_ff;
        end
    end

    assign lnk.ack_tgl = ack_ff;
    assign lnk.rx_byte = rx_ff;
    assign o_sclk = sclk_ff;
    assign o_mosi = mosi_ff;
    assign o_ss_n = ss_n_ff;
endmodule

// ### smb_top.sv
// Purpose: Serial master byte engine: processor or DMA bytes out, slave bytes in
// Assumes: Link clock is free running; the slave answers on the master clock
// Notes: First byte of a transfer is the command byte; a byte tagged last ends it
// Function
// - Only the master starts a transfer, asserting the chosen select before any clock edge.
// - The first byte shifted after the select asserts is the command byte, with the clock made here.
// - Any number of data bytes follow, and the transfer ends only by releasing the select.
// - Every byte stage drives the output line and captures the input line together.
// - Each finished byte sets the transmit-done flag and the receive-full flag.
// - The serial clock has programmable rate, idle polarity and sampling phase.
// - A programmable delay separates select assertion from the first clock edge.
// - Full duplex and both half-duplex directions are supported.
// - Payload bytes are shifted as given, or replaced by a fixed filler in receive-only, and never interpreted.
// - Bytes may be supplied either by the processor port or by the DMA port.
// - Two active-low selects are provided, one per attached slave.
`timescale 1ns/1ps
module smb_top (
    // System clock and reset
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    // Link clock
    input wire logic I_LINK_CLK,
    // Processor byte port
    input wire logic I_CPU_TX_VALID,
    input wire logic [smb_pkg::BYTE_W-1:0] I_CPU_TX_DATA,
    input wire logic I_CPU_TX_LAST,
    output logic O_CPU_TX_READY,
    // DMA byte port
    input wire logic I_DMA_TX_VALID,
    input wire logic [smb_pkg::BYTE_W-1:0] I_DMA_TX_DATA,
    input wire logic I_DMA_TX_LAST,
    output logic O_DMA_TX_READY,
    // Configuration
    input wire logic I_DMA_SEL,
    input wire logic [smb_pkg::DIV_W-1:0] I_CLK_DIV,
    input wire logic I_CPOL,
    input wire logic I_CPHA,
    input wire logic I_SS_SEL,
    input wire logic [smb_pkg::DIV_W-1:0] I_SS_DELAY,
    input wire logic [1:0] I_DUPLEX,
    // Flags and status
    input wire logic I_TX_DONE_CLR,
    input wire logic I_RX_FULL_CLR,
    output logic O_TX_DONE,
    output logic O_RX_FULL,
    output logic [smb_pkg::BYTE_W-1:0] O_RX_DATA,
    output logic O_RX_IS_CMD,
    output logic O_BUSY,
    // Serial pins
    input wire logic I_MISO,
    output logic O_SCLK,
    output logic O_MOSI,
    output logic [smb_pkg::SS_W-1:0] O_SS_N
);
    smb_link_if lnk ();

    smb_pkg::smb_main_e state_ff;
    smb_pkg::smb_duplex_e duplex_ff;
    logic [smb_pkg::BYTE_W-1:0] tx_byte_ff;
    logic [smb_pkg::BYTE_W-1:0] rx_data_ff;
    logic [smb_pkg::DIV_W-1:0] clk_div_ff;
    logic [smb_pkg::DIV_W-1:0] ss_delay_ff;
    logic req_ff, first_ff, last_ff, cpol_ff, cpha_ff, ss_sel_ff;
    logic ack_seen_ff, tx_done_ff, rx_full_ff, rx_is_cmd_ff;
    logic ack_s, lrst;
    logic ready, src_valid, src_last, accept, ack_evt, byte_done;
    logic [smb_pkg::BYTE_W-1:0] src_data;
    logic [smb_pkg::BYTE_W-1:0] nxt_tx_byte;

    // Reset into the link domain
    smb_sync #(.W(1)) u_rst_sync (.i_clk(I_LINK_CLK), .i_d(I_SYS_RST), .o_q(lrst));
    // Acknowledge into the system domain
    smb_sync #(.W(1)) u_ack_sync (.i_clk(I_CLK), .i_d(lnk.ack_tgl), .o_q(ack_s));

    smb_shifter u_shifter (
        .i_lclk(I_LINK_CLK),
        .i_lrst(lrst),
        .lnk(lnk.link),
        .i_miso(I_MISO),
        .o_sclk(O_SCLK),
        .o_mosi(O_MOSI),
        .o_ss_n(O_SS_N)
    );

    // Source choice between processor and DMA
    assign src_valid = I_DMA_SEL ? I_DMA_TX_VALID : I_CPU_TX_VALID;
    assign src_data = I_DMA_SEL ? I_DMA_TX_DATA : I_CPU_TX_DATA;
    assign src_last = I_DMA_SEL ? I_DMA_TX_LAST : I_CPU_TX_LAST;
    assign ready = (state_ff == smb_pkg::M_IDLE) || (state_ff == smb_pkg::M_HOLD);
    assign O_CPU_TX_READY = ready && !I_DMA_SEL;
    assign O_DMA_TX_READY = ready && I_DMA_SEL;
    assign accept = ready && src_valid;
    assign ack_evt = ack_s ^ ack_seen_ff;
    assign byte_done = (state_ff == smb_pkg::M_SEND) && ack_evt;

    // Receive-only sends a fixed filler; the data itself is never looked at
    always_comb begin
        nxt_tx_byte = src_data;
        if (state_ff == smb_pkg::M_IDLE && I_DUPLEX == smb_pkg::DUPLEX_RX_ONLY) begin
            nxt_tx_byte = smb_pkg::RX_ONLY_FILL;
        end else if (state_ff == smb_pkg::M_HOLD && duplex_ff == smb_pkg::DUPLEX_RX_ONLY) begin
            nxt_tx_byte = smb_pkg::RX_ONLY_FILL;
        end
    end

    // Transfer sequencer
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            state_ff <= smb_pkg::M_IDLE;
        end else begin
            unique case (state_ff)
                smb_pkg::M_IDLE: begin
                    if (accept) begin
                        state_ff <= smb_pkg::M_SEND;
                    end
                end
                smb_pkg::M_SEND: begin
                    if (ack_evt) begin
                        state_ff <= last_ff ? smb_pkg::M_IDLE : smb_pkg::M_HOLD;
                    end
                end
                smb_pkg::M_HOLD: begin
                    if (accept) begin
                        state_ff <= smb_pkg::M_SEND;
                    end
                end
            endcase
        end
    end

    // Request fields, held stable across the handshake
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            req_ff <= 1'b0;
            tx_byte_ff <= smb_pkg::BYTE_ZERO;
            first_ff <= 1'b0;
            last_ff <= 1'b0;
        end else if (accept) begin
            req_ff <= ~req_ff;
            tx_byte_ff <= nxt_tx_byte;
            first_ff <= (state_ff == smb_pkg::M_IDLE);
            last_ff <= src_last;
        end
    end

    // Configuration is frozen for a whole transfer
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            clk_div_ff <= smb_pkg::CNT_ZERO;
            ss_delay_ff <= smb_pkg::CNT_ZERO;
            cpol_ff <= 1'b0;
            cpha_ff <= 1'b0;
            ss_sel_ff <= 1'b0;
            duplex_ff <= smb_pkg::DUPLEX_FULL;
        end else if (accept && state_ff == smb_pkg::M_IDLE) begin
            clk_div_ff <= I_CLK_DIV;
            ss_delay_ff <= I_SS_DELAY;
            cpol_ff <= I_CPOL;
            cpha_ff <= I_CPHA;
            ss_sel_ff <= I_SS_SEL;
            duplex_ff <= smb_pkg::smb_duplex_e'(I_DUPLEX);
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            ack_seen_ff <= 1'b0;
        end else if (ack_evt) begin
            ack_seen_ff <= ack_s;
        end
    end

    // Received byte; transmit-only keeps the previous value
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            rx_data_ff <= smb_pkg::BYTE_ZERO;
            rx_is_cmd_ff <= 1'b0;
        end else if (byte_done) begin
            rx_is_cmd_ff <= first_ff;
            if (duplex_ff != smb_pkg::DUPLEX_TX_ONLY) begin
                rx_data_ff <= lnk.rx_byte;
            end
        end
    end

    // Sticky byte flags; a new byte beats a clear in the same cycle
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            tx_done_ff <= 1'b0;
            rx_full_ff <= 1'b0;
        end else begin
            tx_done_ff <= byte_done || (tx_done_ff && !I_TX_DONE_CLR);
            rx_full_ff <= byte_done || (rx_full_ff && !I_RX_FULL_CLR);
        end
    end

    assign lnk.req_tgl = req_ff;
    assign lnk.tx_byte = tx_byte_ff;
    assign lnk.first = first_ff;
    assign lnk.last = last_ff;
    assign lnk.cpol = cpol_ff;
    assign lnk.cpha = cpha_ff;
    assign lnk.ss_sel = ss_sel_ff;
    assign lnk.clk_div = clk_div_ff;
    assign lnk.ss_delay = ss_delay_ff;

    assign O_TX_DONE = tx_done_ff;
    assign O_RX_FULL = rx_full_ff;
    assign O_RX_DATA = rx_data_ff;
    assign O_RX_IS_CMD = rx_is_cmd_ff;
    assign O_BUSY = (state_ff != smb_pkg::M_IDLE);
endmodule

// ### smb_slave_model.sv
// Purpose: Behavioural serial slave on the far side of the byte engine
// Assumes: Mode inputs match the master's for the current transfer
// Notes: A released output shows the inverse of its last value
`timescale 1ns/1ps
module smb_slave_model (
    // Serial pins
    input wire logic i_sclk,
    input wire logic i_mosi,
    input wire logic [smb_pkg::SS_W-1:0] i_ss_n,
    // Mode
    input wire logic i_cpol,
    input wire logic i_cpha,
    output logic o_miso
);
    logic [7:0] resp_q[$];
    logic [7:0] got_q[$];
    logic [7:0] cur;
    logic [7:0] sh;
    int k;
    wire sel = !(&i_ss_n);
    wire samp = i_sclk ^ i_cpol ^ i_cpha;
    initial o_miso = 1'b1;
    function automatic logic [7:0] peek();
        return resp_q.size() ? resp_q[0] : 8'h5a;
    endfunction
    // First answer bit is out before the first clock edge
    always @(posedge sel) begin
        k = 8;
        o_miso <= peek() >> 7;
    end
    always @(negedge sel) o_miso <= ~o_miso;
    // Answer changes on the shifting edge only
    always @(negedge samp) if (sel) o_miso <= (k == 8) ? peek() >> 7 : cur[7-k];
    always @(posedge samp) if (sel) begin
        if (k == 8) begin
            cur = peek();
            if (resp_q.size()) void'(resp_q.pop_front());
            k = 0;
        end
        sh = {sh[6:0], i_mosi};
        k++;
        if (k == 8) got_q.push_back(sh);
    end
endmodule

// ### smb_top_chk.sv
// Purpose: Port-level checks for the serial master byte engine
// Assumes: Configuration held stable across each transfer
// Notes: Bound to smb_top below
`timescale 1ns/1ps
module smb_top_chk (
    // Clocks and reset
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_LINK_CLK,
    // Byte ports and configuration
    input wire logic I_CPU_TX_VALID,
    input wire logic O_CPU_TX_READY,
    input wire logic O_DMA_TX_READY,
    input wire logic I_DMA_SEL,
    input wire logic [smb_pkg::DIV_W-1:0] I_CLK_DIV,
    input wire logic I_CPOL,
    input wire logic I_SS_SEL,
    input wire logic [smb_pkg::DIV_W-1:0] I_SS_DELAY,
    input wire logic I_TX_DONE_CLR,
    // Status and pins
    input wire logic O_TX_DONE,
    input wire logic O_RX_FULL,
    input wire logic O_BUSY,
    input wire logic O_SCLK,
    input wire logic [smb_pkg::SS_W-1:0] O_SS_N
);
    int lead_ff;
    logic wait_ff;
    int lead_min;
    assign lead_min = int'(I_SS_DELAY) + int'(I_CLK_DIV) + 2;
    // Link cycles from select low to the first clock edge
    always_ff @(posedge I_LINK_CLK) begin
        if (I_SYS_RST || &O_SS_N) begin
            lead_ff <= 0;
            wait_ff <= 1'b1;
        end else if (wait_ff) begin
            lead_ff <= lead_ff + 1;
            wait_ff <= !$changed(O_SCLK);
        end
    end
    a_flags_together: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        $rose(O_TX_DONE) |-> $rose(O_RX_FULL)) else $error("flags not set together");
    a_flag_sticky: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        O_TX_DONE && !I_TX_DONE_CLR |=> O_TX_DONE) else $error("done flag lost");
    a_port_ready: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        I_DMA_SEL ? !O_CPU_TX_READY : !O_DMA_TX_READY) else $error("unselected port ready");
    a_accept_busy: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        I_CPU_TX_VALID && O_CPU_TX_READY |=> (O_BUSY && !O_CPU_TX_READY) [*4]) else $error("accept ignored");
    a_busy_end: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        $fell(O_BUSY) |-> O_TX_DONE && O_RX_FULL) else $error("busy ended early");
    a_sclk_idle: assert property (@(posedge I_LINK_CLK) disable iff (I_SYS_RST)
        $fell(&O_SS_N) || $rose(&O_SS_N) |-> O_SCLK == I_CPOL) else $error("clock not idle");
    a_one_select: assert property (@(posedge I_LINK_CLK) disable iff (I_SYS_RST)
        O_SS_N != 2'h0) else $error("both selects low");
    a_select_line: assert property (@(posedge I_LINK_CLK) disable iff (I_SYS_RST)
        !(&O_SS_N) |-> O_SS_N == (I_SS_SEL ? smb_pkg::SS_N_SEL1 : smb_pkg::SS_N_SEL0)) else $error("wrong select");
    a_lead_delay: assert property (@(posedge I_LINK_CLK) disable iff (I_SYS_RST)
        wait_ff && !(&O_SS_N) && $changed(O_SCLK) |-> lead_ff >= lead_min && lead_ff <= lead_min + 1)
        else $error("lead delay wrong");
    c_dma: cover property (@(posedge I_CLK) I_DMA_SEL && O_BUSY);
    c_end: cover property (@(posedge I_CLK) $fell(O_BUSY));
    c_sel1: cover property (@(posedge I_LINK_CLK) !O_SS_N[1]);
endmodule
bind smb_top smb_top_chk u_chk (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_LINK_CLK(I_LINK_CLK),
    .I_CPU_TX_VALID(I_CPU_TX_VALID), .O_CPU_TX_READY(O_CPU_TX_READY), .O_DMA_TX_READY(O_DMA_TX_READY),
    .I_DMA_SEL(I_DMA_SEL), .I_CLK_DIV(I_CLK_DIV), .I_CPOL(I_CPOL), .I_SS_SEL(I_SS_SEL),
    .I_SS_DELAY(I_SS_DELAY), .I_TX_DONE_CLR(I_TX_DONE_CLR), .O_TX_DONE(O_TX_DONE),
    .O_RX_FULL(O_RX_FULL), .O_BUSY(O_BUSY), .O_SCLK(O_SCLK), .O_SS_N(O_SS_N));

// ### smb_top_tb.sv
// Purpose: Self-checking bench for the serial master byte engine
// Assumes: Random transfers from a fixed seed, plus corner cases
// Notes: The slave model answers behind the serial pins
`timescale 1ns/1ps
module smb_top_tb;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rst = 1'b1;
    logic cpu_v = 1'b0, cpu_l = 1'b0, dma_v = 1'b0, dma_l = 1'b0, dma_sel = 1'b0;
    logic cpol = 1'b0, cpha = 1'b0, ss_sel = 1'b0, tclr = 1'b0, rclr = 1'b0;
    logic [7:0] cpu_d = 8'h00, dma_d = 8'h00, div = 8'h02, dly = 8'h00, last_rx = 8'h00;
    logic [1:0] duplex = 2'h0;
    logic cpu_rdy, dma_rdy, tx_done, rx_full, rx_cmd, busy, miso, sclk, mosi;
    logic [7:0] rx_data;
    logic [1:0] ss_n;
    int err_count = 0;
    int checks = 0;
    always #5 clk = ~clk;
    always #32 lclk = ~lclk;
    smb_top DUT (.I_CLK(clk), .I_SYS_RST(rst), .I_LINK_CLK(lclk),
        .I_CPU_TX_VALID(cpu_v), .I_CPU_TX_DATA(cpu_d), .I_CPU_TX_LAST(cpu_l), .O_CPU_TX_READY(cpu_rdy),
        .I_DMA_TX_VALID(dma_v), .I_DMA_TX_DATA(dma_d), .I_DMA_TX_LAST(dma_l), .O_DMA_TX_READY(dma_rdy),
        .I_DMA_SEL(dma_sel), .I_CLK_DIV(div), .I_CPOL(cpol), .I_CPHA(cpha), .I_SS_SEL(ss_sel),
        .I_SS_DELAY(dly), .I_DUPLEX(duplex), .I_TX_DONE_CLR(tclr), .I_RX_FULL_CLR(rclr),
        .O_TX_DONE(tx_done), .O_RX_FULL(rx_full), .O_RX_DATA(rx_data), .O_RX_IS_CMD(rx_cmd),
        .O_BUSY(busy), .I_MISO(miso), .O_SCLK(sclk), .O_MOSI(mosi), .O_SS_N(ss_n));
    smb_slave_model slv (.i_sclk(sclk), .i_mosi(mosi), .i_ss_n(ss_n), .i_cpol(cpol), .i_cpha(cpha),
        .o_miso(miso));
    task automatic stop_test();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Pattern the slave must see: receive-only sends the fixed filler
    function automatic logic [7:0] exp_mosi(input logic [1:0] dx, input logic [7:0] d);
        return (dx == smb_pkg::DUPLEX_RX_ONLY) ? smb_pkg::RX_ONLY_FILL : d;
    endfunction
    // Transmit-only leaves the received byte as it was
    function automatic logic [7:0] exp_rx(input logic [1:0] dx, input logic [7:0] rsp, input logic [7:0] prev);
        return (dx == smb_pkg::DUPLEX_TX_ONLY) ? prev : rsp;
    endfunction
    task automatic tmo();
        chk(32'h0, 32'h1);
        stop_test();
    endtask
    // Offer on both ports; only the selected one may take its byte
    task automatic send(input logic dm, input logic [7:0] d, input logic lst, input logic cmd, input logic [7:0] rsp);
        int n;
        n = 0;
        @(posedge clk);
        cpu_v <= 1'b1;
        dma_v <= 1'b1;
        cpu_d <= dm ? ~d : d;
        dma_d <= dm ? d : ~d;
        cpu_l <= lst;
        dma_l <= lst;
        tclr <= 1'b1;
        rclr <= 1'b1;
        @(negedge clk);
        while ((dm ? dma_rdy : cpu_rdy) !== 1'b1) begin
            if (++n > 300) tmo();
            @(negedge clk);
        end
        chk(dm ? cpu_rdy : dma_rdy, 1'b0);
        @(posedge clk);
        cpu_v <= 1'b0;
        dma_v <= 1'b0;
        tclr <= 1'b0;
        rclr <= 1'b0;
        @(negedge clk);
        chk({busy, tx_done, rx_full}, 3'b100);
        n = 0;
        while (tx_done !== 1'b1) begin
            if (++n > 5000) tmo();
            @(negedge clk);
        end
        chk({rx_full, rx_cmd}, {1'b1, cmd});
        last_rx = exp_rx(duplex, rsp, last_rx);
        chk(rx_data, last_rx);
    endtask
    task automatic xfer(input logic dm, input int nb, input logic [1:0] dx, input logic [7:0] dv, input logic [7:0] dl);
        logic [7:0] d_q[$];
        logic [7:0] r_q[$];
        @(posedge clk);
        dma_sel <= dm;
        duplex <= dx;
        div <= dv;
        dly <= dl;
        cpol <= 1'($urandom);
        cpha <= 1'($urandom);
        ss_sel <= 1'($urandom);
        // Answers queue up front: in phase 0 the slave shows a byte's first bit as the byte before it ends
        for (int i = 0; i < nb; i++) begin
            d_q.push_back(8'($urandom));
            r_q.push_back(8'($urandom));
            slv.resp_q.push_back(r_q[i]);
        end
        for (int i = 0; i < nb; i++) begin
            send(dm, d_q[i], i == nb - 1, i == 0, r_q[i]);
            if (i == 0 && nb > 1) chk(ss_n, ss_sel ? 2'h1 : 2'h2);
        end
        repeat (2) @(negedge lclk);
        chk({ss_n, sclk, busy}, {2'h3, cpol, 1'b0});
        chk(slv.got_q.size(), nb);
        foreach (d_q[i]) chk(slv.got_q.pop_front(), exp_mosi(dx, d_q[i]));
        slv.got_q.delete();
    endtask
    initial begin
        void'($urandom(32'ha2fa5cee));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge lclk);
        // Corners: command only, longest lead, each duplex mode, both ports
        xfer(1'b0, 1, 2'h0, 8'h02, 8'h00);
        xfer(1'b1, 3, 2'h1, 8'h02, 8'hff);
        xfer(1'b0, 2, 2'h2, 8'h03, 8'h00);
        xfer(1'b1, 2, 2'h3, 8'h04, 8'h01);
        for (int i = 0; i < 8; i++)
            xfer(1'($urandom), 1 + $urandom % 4, 2'($urandom % 3), 8'(2 + $urandom % 4), 8'($urandom % 8));
        // Reset in mid-byte drops the transfer and the flags
        @(posedge clk);
        dma_sel <= 1'b0;
        cpu_v <= 1'b1;
        cpu_l <= 1'b0;
        repeat (60) @(posedge clk);
        rst <= 1'b1;
        cpu_v <= 1'b0;
        repeat (40) @(posedge clk);
        chk({busy, tx_done, rx_full, ss_n, rx_data}, {5'h03, 8'h00});
        rst <= 1'b0;
        last_rx = 8'h00;
        repeat (4) @(posedge lclk);
        slv.resp_q.delete();
        slv.got_q.delete();
        xfer(1'b0, 2, 2'h0, 8'h02, 8'h03);
        stop_test();
    end
endmodule
